/* File: csrc_channel.sv */
/*
 * one channel of a clocked three-wire serial unit, single master, with
 * run/stop control, pin hand-over to the port latch, and an avalon-mm slave.
 * assumes one 125 mhz clock; serial input sdi arrives from outside the
 * domain and is synchronised; the avalon master holds requests until
 * waitrequest is seen low.
 */
//
// Behaviour
// - stop trigger write clears enable status, halts clock, enters stopped state
// - while stopped, clock pin shows the clock output level bit AND the clock port latch bit
// - output enable zero: data pin shows the data output level bit AND the data port latch bit
// - while stopped with output enable zero, each pin is level bit AND port latch bit
// - start trigger write sets enable status; the serial clock runs only once a transmit data write starts a frame
// - output enable one: data pin carries shifted serial data
// - tx and rx both one is full duplex; both zero disables communication
// - level register writes ignored while enable status and output enable are one
// - tx one with rx zero is transmit-only operation (receive still shifts sdi into rx_data, as in full duplex)
// - frames are eight bits, most significant bit first
`timescale 1ns/1ps
`include "csrc_params.svh"

module csrc_channel #(
    parameter int FRAME_BITS = `CSRC_FRAME_BITS
) (
    // clock and reset
    input  wire logic               clock_in,
    input  wire logic               nrst_in,
    // avalon-mm slave
    input  wire csrc_pkg::csrc_req_s avs_req_in,
    output csrc_pkg::csrc_rsp_s      avs_rsp_out,
    // serial pins
    output csrc_pkg::csrc_pins_s     pins_out,
    input  wire logic               sdi_in,
    // interrupt
    output logic                    irq_out
);
    import csrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic                 enabled;      // channel enable status
    logic                 out_en;       // serial output enable
    logic [1:0]           out_level;    // {clock level, data level}
    logic [1:0]           port_latch;   // {clock latch, data latch}
    logic [1:0]           cfg;          // {rx enable, tx enable}
    logic [7:0]           divider;
    logic [7:0]           div_cnt;
    logic [FRAME_BITS-1:0] shift_tx;
    logic [FRAME_BITS-1:0] shift_rx;
    logic [FRAME_BITS-1:0] rx_data;
    logic [3:0]           bit_cnt;
    logic                 busy;
    logic                 sck;
    logic                 sdo;
    logic                 irq_stat;
    logic                 irq_mask;
    logic                 rsp_valid;
    logic [31:0]          rdata;
    logic                 sdi_meta;
    logic                 sdi_sync;

    logic                 next_enabled;
    logic                 next_out_en;
    logic [1:0]           next_out_level;
    logic [1:0]           next_port_latch;
    logic [1:0]           next_cfg;
    logic [7:0]           next_divider;
    logic [7:0]           next_div_cnt;
    logic [FRAME_BITS-1:0] next_shift_tx;
    logic [FRAME_BITS-1:0] next_shift_rx;
    logic [FRAME_BITS-1:0] next_rx_data;
    logic [3:0]           next_bit_cnt;
    logic                 next_busy;
    logic                 next_sck;
    logic                 next_sdo;
    logic                 next_irq_stat;
    logic                 next_irq_mask;
    logic                 next_rsp_valid;
    logic [31:0]          next_rdata;

    csrc_dir_e            dir;
    logic                 wr;
    logic                 rd;
    logic                 frame_end;
    logic                 tick;

    ////////////////////////////////////////////////////////////////////////
    // direction decode
    always_comb begin
        unique case (cfg)
            2'h3:    dir = CSRC_DIR_TRX;
            2'h1:    dir = CSRC_DIR_TX;
            2'h2:    dir = CSRC_DIR_RX;
            default: dir = CSRC_DIR_OFF;
        endcase
    end

    // one-cycle waitrequest: request accepted the cycle after it appears;
    // read data load in the first cycle so they stand at the accepting edge
    assign wr = avs_req_in.write & rsp_valid;
    assign rd = avs_req_in.read & ~rsp_valid;
    assign tick = (div_cnt == divider);
    // frame ends at the last rising serial clock edge, once the last bit is sampled
    assign frame_end = busy & tick & ~sck & (bit_cnt == 4'(FRAME_BITS - 1));

    ////////////////////////////////////////////////////////////////////////
    // sdi synchroniser
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else begin
            sdi_meta <= sdi_in;
            sdi_sync <= sdi_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file, run control and shifter next values
    always_comb begin
        next_enabled    = enabled;
        next_out_en     = out_en;
        next_out_level  = out_level;
        next_port_latch = port_latch;
        next_cfg        = cfg;
        next_divider    = divider;
        next_div_cnt    = div_cnt;
        next_shift_tx   = shift_tx;
        next_shift_rx   = shift_rx;
        next_rx_data    = rx_data;
        next_bit_cnt    = bit_cnt;
        next_busy       = busy;
        next_sck        = sck;
        next_sdo        = sdo;
        next_irq_stat   = irq_stat;
        next_irq_mask   = irq_mask;
        next_rsp_valid  = (avs_req_in.read | avs_req_in.write) & ~rsp_valid;
        next_rdata      = rdata;

        // serial engine: one half bit per divider period, clock idles high
        if (busy) begin
            next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
            if (tick) begin
                next_sck = ~sck;
                if (sck) begin
                    // falling edge: drive next data bit
                    next_sdo = (dir != CSRC_DIR_RX) ? shift_tx[FRAME_BITS-1] : 1'b1;
                    next_shift_tx = {shift_tx[FRAME_BITS-2:0], 1'b0};
                end else begin
                    // rising edge: sample, count bits
                    next_shift_rx = {shift_rx[FRAME_BITS-2:0], sdi_sync};
                    next_bit_cnt  = bit_cnt + 4'h1;
                    if (bit_cnt == 4'(FRAME_BITS - 1)) begin
                        next_busy    = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_rx_data = {shift_rx[FRAME_BITS-2:0], sdi_sync};
                    end
                end
            end
        end

        if (wr) begin
            unique case (avs_req_in.address)
                `CSRC_START_OFS: begin
                    if (avs_req_in.writedata[0])
                        next_enabled = 1'b1;
                end
                `CSRC_STOP_OFS: begin
                    if (avs_req_in.writedata[0]) begin
                        next_enabled = 1'b0;
                        next_busy    = 1'b0;
                        next_sck     = 1'b1;
                        next_bit_cnt = 4'h0;
                        next_div_cnt = 8'h00;
                    end
                end
                `CSRC_OUT_EN_OFS:    next_out_en = avs_req_in.writedata[0];
                `CSRC_OUT_LEVEL_OFS: begin
                    if (!(enabled && out_en))
                        next_out_level = avs_req_in.writedata[1:0];
                end
                `CSRC_CONFIG_OFS: begin
                    if (!enabled)
                        next_cfg = avs_req_in.writedata[1:0];
                end
                `CSRC_PORT_OFS:      next_port_latch = avs_req_in.writedata[1:0];
                `CSRC_DIVIDER_OFS: begin
                    if (!enabled)
                        next_divider = avs_req_in.writedata[7:0];
                end
                `CSRC_TXDATA_OFS: begin
                    // a frame starts only on an enabled channel with a direction
                    if (enabled && !busy && dir != CSRC_DIR_OFF) begin
                        next_shift_tx = avs_req_in.writedata[FRAME_BITS-1:0];
                        next_busy     = 1'b1;
                        next_sck      = 1'b1;
                        next_div_cnt  = 8'h00;
                        next_sdo      = (dir != CSRC_DIR_RX) ?
                                        avs_req_in.writedata[FRAME_BITS-1] : 1'b1;
                    end
                end
                `CSRC_IRQ_STAT_OFS: begin
                    if (avs_req_in.writedata[`CSRC_IRQ_END_BIT])
                        next_irq_stat = 1'b0;
                end
                `CSRC_IRQ_MASK_OFS:  next_irq_mask = avs_req_in.writedata[0];
                default: ;
            endcase
        end

        // set wins over clear
        if (frame_end)
            next_irq_stat = 1'b1;

        if (rd) begin
            unique case (avs_req_in.address)
                `CSRC_STATUS_OFS:    next_rdata = {30'h0, busy, enabled};
                `CSRC_OUT_EN_OFS:    next_rdata = {31'h0, out_en};
                `CSRC_OUT_LEVEL_OFS: next_rdata = {30'h0, out_level};
                `CSRC_CONFIG_OFS:    next_rdata = {30'h0, cfg};
                `CSRC_PORT_OFS:      next_rdata = {30'h0, port_latch};
                `CSRC_DIVIDER_OFS:   next_rdata = {24'h0, divider};
                `CSRC_RXDATA_OFS:    next_rdata = {{(32-FRAME_BITS){1'b0}}, rx_data};
                `CSRC_IRQ_STAT_OFS:  next_rdata = {31'h0, irq_stat};
                `CSRC_IRQ_MASK_OFS:  next_rdata = {31'h0, irq_mask};
                default:             next_rdata = `CSRC_UNMAPPED_DATA;
            endcase
        end
    end

    // register all state
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            enabled    <= 1'b0;
            out_en     <= 1'b0;
            out_level  <= `CSRC_OUT_LEVEL_RST;
            port_latch <= `CSRC_PORT_RST;
            cfg        <= 2'h0;
            divider    <= `CSRC_DIVIDER_RST;
            div_cnt    <= 8'h00;
            shift_tx   <= '0;
            shift_rx   <= '0;
            rx_data    <= '0;
            bit_cnt    <= 4'h0;
            busy       <= 1'b0;
            sck        <= 1'b1;
            sdo        <= 1'b1;
            irq_stat   <= 1'b0;
            irq_mask   <= 1'b0;
            rsp_valid  <= 1'b0;
            rdata      <= 32'h0;
        end else begin
            enabled    <= next_enabled;
            out_en     <= next_out_en;
            out_level  <= next_out_level;
            port_latch <= next_port_latch;
            cfg        <= next_cfg;
            divider    <= next_divider;
            div_cnt    <= next_div_cnt;
            shift_tx   <= next_shift_tx;
            shift_rx   <= next_shift_rx;
            rx_data    <= next_rx_data;
            bit_cnt    <= next_bit_cnt;
            busy       <= next_busy;
            sck        <= next_sck;
            sdo        <= next_sdo;
            irq_stat   <= next_irq_stat;
            irq_mask   <= next_irq_mask;
            rsp_valid  <= next_rsp_valid;
            rdata      <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin multiplexing between serial function and port
    always_comb begin
        if (enabled)
            pins_out.sck = sck;
        else
            pins_out.sck = out_level[`CSRC_LVL_CLK_BIT]
                         & port_latch[`CSRC_LVL_CLK_BIT];
        if (out_en)
            pins_out.sdo = sdo;
        else
            pins_out.sdo = out_level[`CSRC_LVL_DATA_BIT]
                         & port_latch[`CSRC_LVL_DATA_BIT];
    end

    // bus answer and interrupt
    assign avs_rsp_out.waitrequest = (avs_req_in.read | avs_req_in.write) & ~rsp_valid;
    assign avs_rsp_out.readdata    = rdata;
    assign irq_out                 = irq_stat & irq_mask;

endmodule

/* File: csrc_checker.sv */
/*
 * run-control checker for csrc_channel: pin hand-over, frame start/end, irq.
 * assumes it is bound to csrc_channel and sees only its ports.
 */
`timescale 1ns/1ps
`include "csrc_params.svh"
module csrc_checker #(
    parameter int FRAME_BITS = 8
) (
    // clock and reset
    input wire logic                clock_in,
    input wire logic                nrst_in,
    // watched ports
    input wire csrc_pkg::csrc_req_s  avs_req_in,
    input wire csrc_pkg::csrc_rsp_s  avs_rsp_out,
    input wire csrc_pkg::csrc_pins_s pins_out,
    input wire logic                sdi_in,
    input wire logic                irq_out
);
    import csrc_pkg::*;
    logic       aw;
    logic [7:0] ad;
    logic [1:0] wd;
    logic       en, oen, msk, sck_q;
    logic [1:0] lvl, lat, cfg;
    logic [3:0] rc;
    assign aw = avs_req_in.write & ~avs_rsp_out.waitrequest;
    assign ad = avs_req_in.address;
    assign wd = avs_req_in.writedata[1:0];
    // shadow of the control bits, built from accepted writes only
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            {en, oen, msk, cfg, rc} <= '0;
            {lvl, lat, sck_q} <= 5'h1f;
        end else begin
            sck_q <= pins_out.sck;
            if (aw && ad == `CSRC_START_OFS && wd[0]) en <= 1'b1;
            if (aw && ad == `CSRC_STOP_OFS && wd[0]) en <= 1'b0;
            if (aw && ad == `CSRC_OUT_EN_OFS) oen <= wd[0];
            if (aw && ad == `CSRC_OUT_LEVEL_OFS && !(en && oen)) lvl <= wd;
            if (aw && ad == `CSRC_PORT_OFS) lat <= wd;
            if (aw && ad == `CSRC_CONFIG_OFS && !en) cfg <= wd;
            if (aw && ad == `CSRC_IRQ_MASK_OFS) msk <= wd[0];
            // rising serial clock edges since the last frame start
            if (aw && ad == `CSRC_TXDATA_OFS) rc <= '0;
            else if (pins_out.sck && !sck_q) rc <= rc + 4'h1;
        end
    end
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    a_stop_clk_level: assert property (!en |-> pins_out.sck == (lvl[1] & lat[1]))
        else $error("clock pin not at held level while stopped");
    a_sdo_held: assert property (!oen |-> pins_out.sdo == (lvl[0] & lat[0]))
        else $error("data pin not at held level while output off");
    a_stop_abort: assert property (aw && ad == `CSRC_STOP_OFS && wd[0]
        |=> (pins_out.sck == (lvl[1] & lat[1]))[*4])
        else $error("clock kept running after stop");
    a_start_clk: assert property (aw && ad == `CSRC_TXDATA_OFS && en && cfg != 2'h0
        |-> ##[2:600] !pins_out.sck)
        else $error("no serial clock after frame start");
    a_sdo_msb: assert property (aw && ad == `CSRC_TXDATA_OFS && en && oen && cfg[0]
        |=> pins_out.sdo == $past(avs_req_in.writedata[7]))
        else $error("first data bit is not the msb");
    a_off_no_clock: assert property (en && cfg == 2'h0 |-> pins_out.sck)
        else $error("serial clock runs with communication off");
    a_frame_end: assert property ($rose(irq_out) && $stable(msk)
        |-> rc + 4'(pins_out.sck & !sck_q) == FRAME_BITS)
        else $error("frame end not after eight clock rises");
    a_irq_masked: assert property (!msk |-> !irq_out)
        else $error("interrupt while masked");
    c_frame: cover property ($rose(irq_out));
    c_stop: cover property (aw && ad == `CSRC_STOP_OFS && en);
    c_lvl_blocked: cover property (aw && ad == `CSRC_OUT_LEVEL_OFS && en && oen);
endmodule
bind csrc_channel csrc_checker #(.FRAME_BITS(FRAME_BITS)) chk_u (.clock_in(clock_in),
    .nrst_in(nrst_in), .avs_req_in(avs_req_in), .avs_rsp_out(avs_rsp_out),
    .pins_out(pins_out), .sdi_in(sdi_in), .irq_out(irq_out));

/* File: csrc_mem_model.sv */
/*
 * serial memory slave: shifts a reply byte out, msb first, and captures data.
 * assumes clock idles high; sel_in low resets the bit count between frames.
 */
`timescale 1ns/1ps
module csrc_mem_model (
    // serial pins
    input  wire logic       sck_in,
    input  wire logic       sdo_in,
    input  wire logic       sel_in,
    output logic            sdi_out,
    // reply and captured byte
    input  wire logic [7:0] reply_in,
    output logic [7:0]      got_out
);
    int cnt = 0;
    initial sdi_out = 1'b0;
    initial got_out = 8'h00;
    // next reply bit on the falling edge
    always @(negedge sck_in) if (sel_in) sdi_out = reply_in[7 - cnt];
    // capture on the rising edge; after the last bit the line is inverted
    always @(posedge sck_in) if (sel_in) begin
        got_out = {got_out[6:0], sdo_in};
        cnt = cnt + 1;
        if (cnt == 8) begin
            cnt = 0;
            sdi_out = ~sdi_out;
        end
    end
    // deselect: restart count, invert the line (after a full frame it shows the last bit again)
    always @(negedge sel_in) begin
        cnt = 0;
        sdi_out = ~sdi_out;
    end
endmodule

/* File: csrc_params.svh */
/*
 * constants of the serial channel run-control block: register offsets,
 * field positions, reset values and timing counts.
 * assumes inclusion once per compilation unit by its bare name.
 */
`ifndef CSRC_PARAMS_SVH
`define CSRC_PARAMS_SVH

// register byte offsets (word aligned)
`define CSRC_START_OFS      8'h00
`define CSRC_STOP_OFS       8'h04
`define CSRC_STATUS_OFS     8'h08
`define CSRC_OUT_EN_OFS     8'h0c
`define CSRC_OUT_LEVEL_OFS  8'h10
`define CSRC_CONFIG_OFS     8'h14
`define CSRC_PORT_OFS       8'h18
`define CSRC_TXDATA_OFS     8'h1c
`define CSRC_RXDATA_OFS     8'h20
`define CSRC_IRQ_STAT_OFS   8'h24
`define CSRC_IRQ_MASK_OFS   8'h28
`define CSRC_DIVIDER_OFS    8'h2c

// field positions
`define CSRC_LVL_DATA_BIT   0
`define CSRC_LVL_CLK_BIT    1
`define CSRC_CFG_TX_BIT     0
`define CSRC_CFG_RX_BIT     1
`define CSRC_STAT_BUSY_BIT  1
`define CSRC_IRQ_END_BIT    0

// reset values
`define CSRC_OUT_LEVEL_RST  2'h3
`define CSRC_PORT_RST       2'h3
`define CSRC_DIVIDER_RST    8'h03

// frame length in bits
`define CSRC_FRAME_BITS     8

// answer to an unmapped read
`define CSRC_UNMAPPED_DATA  32'h0000_0000

`endif

/* File: csrc_pkg.sv */
/*
 * types of the serial channel run-control block.
 * assumes csrc_params.svh is available on the include path.
 */
package csrc_pkg;

    // transfer direction decoded from the two enable bits
    typedef enum logic [1:0] {
        CSRC_DIR_OFF,
        CSRC_DIR_TX,
        CSRC_DIR_RX,
        CSRC_DIR_TRX
    } csrc_dir_e;

    // avalon-mm request from the master
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } csrc_req_s;

    // avalon-mm answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } csrc_rsp_s;

    // serial pins towards the memory
    typedef struct packed {
        logic sck;
        logic sdo;
    } csrc_pins_s;

endpackage

/* File: tb.sv */
/*
 * testbench for csrc_channel: register tasks on avalon-mm, start/stop runs.
 * assumes the checker is bound and the memory model answers on the pins.
 */
`timescale 1ns/1ps
`include "csrc_params.svh"
module tb;
    import csrc_pkg::*;
    logic        clock_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        sdi, irq;
    logic        sel = 1'b0;
    csrc_req_s   req = '0;
    csrc_rsp_s   rsp;
    csrc_pins_s  pins;
    logic [7:0]  got;
    logic [31:0] d;
    int          fails = 0;
    int          n_checks = 0;
    always #4 clock_in = ~clock_in;
    csrc_channel dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .avs_req_in(req),
        .avs_rsp_out(rsp), .pins_out(pins), .sdi_in(sdi), .irq_out(irq));
    csrc_mem_model mem_u (.sck_in(pins.sck), .sdo_in(pins.sdo), .sel_in(sel),
        .sdi_out(sdi), .reply_in(8'h3c), .got_out(got));
    ////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low
    task bus(input logic rw, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clock_in);
        req <= '{address: a, read: rw, write: !rw, writedata: wd, byteenable: 4'hf};
        for (k = 0; k < 20; k++) begin
            @(posedge clock_in);
            if (rsp.waitrequest === 1'b0) break;
        end
        // read data stand at the accepting edge and are taken there
        d = rsp.readdata;
        req <= '0;
        if (k == 20) begin
            fails++;
            results;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b0, a, v);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        chk(d, e);
    endtask
    // compares {irq, sck, sdo} under a mask
    task chkp(input logic [2:0] e, input logic [2:0] m = 3'h7);
        @(posedge clock_in);
        chk({29'h0, {irq, pins} & m}, {29'h0, e});
    endtask
    task wait_irq;
        int k;
        for (k = 0; k < 2000; k++) begin
            @(posedge clock_in);
            if (irq === 1'b1) break;
        end
        if (k == 2000) begin
            fails++;
            results;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd(`CSRC_OUT_LEVEL_OFS, 32'h3);
        rd(`CSRC_PORT_OFS, 32'h3);
        rd(`CSRC_DIVIDER_OFS, 32'h3);
        rd(8'h30, 32'h0);
        chkp(3'h3);
        wr(`CSRC_PORT_OFS, 32'h1);
        chkp(3'h1);
        wr(`CSRC_OUT_LEVEL_OFS, 32'h2);
        chkp(3'h0);
        wr(`CSRC_PORT_OFS, 32'h3);
        chkp(3'h2);
        // full duplex run, transmit-only run, then receive-only run (sends ones)
        for (int i = 0; i < 3; i++) begin
            wr(`CSRC_CONFIG_OFS, (i == 0) ? 32'h3 : (i == 1) ? 32'h1 : 32'h2);
            wr(`CSRC_OUT_LEVEL_OFS, 32'h3);
            wr(`CSRC_OUT_EN_OFS, 32'h1);
            wr(`CSRC_DIVIDER_OFS, 32'h7);
            wr(`CSRC_IRQ_MASK_OFS, 32'h1);
            wr(`CSRC_START_OFS, 32'h1);
            rd(`CSRC_STATUS_OFS, 32'h1);
            wr(`CSRC_OUT_LEVEL_OFS, 32'h0);
            sel <= 1'b1;
            wr(`CSRC_TXDATA_OFS, (i == 1) ? 32'h81 : 32'ha5);
            wait_irq;
            chk({24'h0, got}, (i == 0) ? 32'ha5 : (i == 1) ? 32'h81 : 32'hff);
            if (i != 1) rd(`CSRC_RXDATA_OFS, 32'h3c);
            sel <= 1'b0;
            wr(`CSRC_IRQ_MASK_OFS, 32'h0);
            chkp(3'h0, 3'h4);
            wr(`CSRC_IRQ_MASK_OFS, 32'h1);
            chkp(3'h4, 3'h4);
            wr(`CSRC_IRQ_STAT_OFS, 32'h1);
            chkp(3'h0, 3'h4);
            wr(`CSRC_STOP_OFS, 32'h1);
            rd(`CSRC_STATUS_OFS, 32'h0);
            wr(`CSRC_OUT_EN_OFS, 32'h0);
            rd(`CSRC_OUT_LEVEL_OFS, 32'h3);
            chkp(3'h3);
            wr(`CSRC_CONFIG_OFS, 32'h0);
        end
        // started with both direction bits clear: no frame
        wr(`CSRC_OUT_EN_OFS, 32'h1);
        wr(`CSRC_START_OFS, 32'h1);
        wr(`CSRC_TXDATA_OFS, 32'h55);
        repeat (200) @(posedge clock_in);
        chkp(3'h2, 3'h6);
        // stop in mid-frame
        wr(`CSRC_STOP_OFS, 32'h1);
        wr(`CSRC_CONFIG_OFS, 32'h3);
        wr(`CSRC_START_OFS, 32'h1);
        sel <= 1'b1;
        wr(`CSRC_TXDATA_OFS, 32'hff);
        repeat (20) @(posedge clock_in);
        wr(`CSRC_STOP_OFS, 32'h1);
        chkp(3'h2, 3'h6);
        rd(`CSRC_STATUS_OFS, 32'h0);
        repeat (300) @(posedge clock_in);
        chkp(3'h2, 3'h6);
        results;
    end
endmodule
